//--- ses_pkg.sv
/*
 * shared constants and carriers for the shared error steering block.
 * assumes one core clock domain and at most 64 strands.
 */
package ses_pkg;

    // ==========================================================
    // handler field and sizes
    localparam int SES_ID_W = 6;
    localparam int SES_MAX_STRANDS = 64;
    localparam int SES_CODE_W = 8;
    localparam int SES_ASI_W = 8;
    localparam int SES_VA_W = 16;
    localparam int SES_DATA_W = 64;
    localparam logic [SES_ID_W-1:0] SES_HANDLER_RST = 6'h00;

    // ==========================================================
    // alternate-space location of the steering register
    localparam logic [SES_ASI_W-1:0] SES_STEER_ASI = 8'h5a;
    localparam logic [SES_VA_W-1:0] SES_STEER_VA = 16'h0040;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic shared;
        logic traceable;
        logic sync;
        logic [SES_ID_W-1:0] strand;
        logic [SES_CODE_W-1:0] code;
    } ses_err_type;

    typedef struct packed {
        logic sync;
        logic steered;
        logic [SES_CODE_W-1:0] code;
    } ses_rpt_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [SES_ASI_W-1:0] alternate_space_id;
        logic [SES_VA_W-1:0] va;
        logic [SES_DATA_W-1:0] wdata;
    } ses_asi_req_type;

    // ==========================================================
    // helpers
    function automatic logic [SES_ID_W-1:0] ses_lowest(
        input logic [SES_MAX_STRANDS-1:0] v);
        logic [SES_ID_W-1:0] r;
        r = SES_HANDLER_RST;
        for (int i = SES_MAX_STRANDS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = SES_ID_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [SES_MAX_STRANDS-1:0] ses_onehot(
        input logic [SES_ID_W-1:0] n);
        logic [SES_MAX_STRANDS-1:0] r;
        r = '0;
        r[n] = 1'b1;
        return r;
    endfunction

endpackage

//--- ses_trap_hold.sv
/*
 * per-strand exception holding: a delivered error leaves an exception
 * pending until the strand is running, then one pulse is raised.
 * assumes parked status comes from logic on the same clock.
 */
`timescale 1ns/1ps
module ses_trap_hold #(
    parameter int N = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] parked,
    // status
    output logic [N-1:0] pend,
    output logic [N-1:0] trap
);

    // ==========================================================
    // pending and firing
    logic [N-1:0] pend_ff;
    logic [N-1:0] trap_ff;
    logic [N-1:0] fire;
    logic [N-1:0] nxt_pend;

    // a parked strand keeps its exception until it runs again
    assign fire = pend_ff & ~parked;
    // a new delivery wins over the clear of a firing one
    assign nxt_pend = (pend_ff & ~fire) | set;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_ff <= '0;
        end else begin
            trap_ff <= fire;
        end
    end

    assign pend = pend_ff;
    assign trap = trap_ff;

    // ==========================================================
    // checks
    property p_parked_hold;
        @(posedge clk) disable iff (!rst_n)
        (trap_ff & $past(parked)) == '0;
    endproperty
    a_parked_hold: assert property (p_parked_hold)
        else $error("exception raised on a parked strand");

    // a firing strand with no fresh delivery must not fire again
    logic [N-1:0] fire_once;
    assign fire_once = fire & ~set;

    property p_unpark_fire;
        @(posedge clk) disable iff (!rst_n)
        fire != '0 |=> trap_ff == $past(fire)
            ##1 (trap_ff & $past(fire_once, 2)) == '0;
    endproperty
    a_unpark_fire: assert property (p_unpark_fire)
        else $error("pending exception not raised once");

endmodule // ses_trap_hold

//--- ses_error_steer.sv
/*
 * error steering for a multi_strand_chip: routes strand-specific errors
 * back to their strand and steers untraceable shared errors to the
 * strand named by error_handler_select, reached by alternate-space
 * loads and stores. assumes error, status and access inputs come from
 * logic on CLOCK, and a single steering register covers all strands.
 */
// What this block does
// - private errors go only to owning strand
// - traceable shared errors return to originating strand
// - untraceable shared errors use the steering path
// - record error, then raise exception, one strand
// - any sharing strand may be chosen handler
// - steered errors go to the named strand
// - record and exception on same target strand
// - handler chosen by encoded number, not mask
// - handler field six bits, fits top strand
// - steering register holds only the handler field
// - register read and written by alternate space
// - one common register covers all strands
// - unavailable target leaves enabled strands untouched
// - parked target gets report, traps after unpark
// - store takes effect before barrier completes
// - racing change: record and trap stay together
// - reset names lowest available or enabled strand
// - unimplemented upper handler bits read zero
`timescale 1ns/1ps
module ses_error_steer #(
    parameter int NUM_STRANDS = 64
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic WARM_RESET,
    // error detection
    input wire ses_pkg::ses_err_type ERR_IN,
    // strand status
    input wire logic [NUM_STRANDS-1:0] STRAND_AVAILABLE,
    input wire logic [NUM_STRANDS-1:0] STRAND_ENABLE,
    input wire logic [NUM_STRANDS-1:0] STRAND_PARKED,
    // alternate-space access
    input wire ses_pkg::ses_asi_req_type ASI_REQ,
    output logic ASI_ACK,
    output logic [ses_pkg::SES_DATA_W-1:0] ASI_RDATA,
    // ordering barrier
    input wire logic BAR_REQ,
    output logic BAR_DONE,
    // strand reporting
    output logic [NUM_STRANDS-1:0] REPORT_VALID,
    output ses_pkg::ses_rpt_type REPORT_INFO,
    output logic [NUM_STRANDS-1:0] TRAP_REQ,
    output logic [ses_pkg::SES_ID_W-1:0] HANDLER
);

    // ==========================================================
    // sizes
    localparam int IMPL_W = (NUM_STRANDS > 1) ? $clog2(NUM_STRANDS) : 1;
    localparam int IDW = ses_pkg::SES_ID_W;
    localparam int MAXS = ses_pkg::SES_MAX_STRANDS;
    localparam logic [IDW:0] ID_SPAN = 7'h01 << IMPL_W;
    localparam logic [IDW-1:0] ID_MASK = IDW'(ID_SPAN - 7'h01);

    function automatic logic [NUM_STRANDS-1:0] onehot_n(
        input logic [IDW-1:0] s);
        logic [MAXS-1:0] w;
        w = ses_pkg::ses_onehot(s);
        return w[NUM_STRANDS-1:0];
    endfunction

    // ==========================================================
    // status widened to the full strand range
    logic [MAXS-1:0] avail_w;
    logic [MAXS-1:0] enab_w;

    always_comb begin
        avail_w = '0;
        enab_w = '0;
        avail_w[NUM_STRANDS-1:0] = STRAND_AVAILABLE;
        enab_w[NUM_STRANDS-1:0] = STRAND_ENABLE;
    end

    // ==========================================================
    // alternate-space decode
    logic asi_hit;
    logic wr_now;
    logic rd_now;

    always_comb begin
        asi_hit = 1'b0;
        if (ASI_REQ.alternate_space_id == ses_pkg::SES_STEER_ASI
            && ASI_REQ.va == ses_pkg::SES_STEER_VA) begin
            asi_hit = 1'b1;
        end
    end

    assign wr_now = ASI_REQ.valid & ASI_REQ.write & asi_hit;
    assign rd_now = ASI_REQ.valid & ~ASI_REQ.write & asi_hit;

    // ==========================================================
    // handler register
    logic [IDW-1:0] handler_ff;
    logic por_init_ff;
    logic wr_pend_ff;
    logic [IDW-1:0] wr_data_ff;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            por_init_ff <= 1'b1;
        end else begin
            por_init_ff <= 1'b0;
        end
    end

    // stores are posted one cycle; the barrier waits them out
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_pend_ff <= 1'b0;
            wr_data_ff <= ses_pkg::SES_HANDLER_RST;
        end else begin
            wr_pend_ff <= wr_now;
            if (wr_now) begin
                wr_data_ff <= ASI_REQ.wdata[IDW-1:0];
            end
        end
    end

    // reset value is caught after release, not under the reset
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            handler_ff <= ses_pkg::SES_HANDLER_RST;
        end else if (por_init_ff) begin
            handler_ff <= ses_pkg::ses_lowest(avail_w);
        end else if (WARM_RESET) begin
            handler_ff <= ses_pkg::ses_lowest(enab_w);
        end else if (wr_pend_ff) begin
            // only the encoded field is kept; upper bits drop
            handler_ff <= wr_data_ff & ID_MASK;
        end
    end

    // ==========================================================
    // read answer
    logic ack_ff;
    logic [ses_pkg::SES_DATA_W-1:0] rdata_ff;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff <= ASI_REQ.valid;
            rdata_ff <= '0;
            if (rd_now) begin
                rdata_ff[IDW-1:0] <= handler_ff & ID_MASK;
            end
        end
    end

    // ==========================================================
    // ordering barrier
    logic bar_wait_ff;
    logic bar_done_ff;
    logic bar_fin;

    assign bar_fin = bar_wait_ff & ~wr_pend_ff;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            bar_wait_ff <= 1'b0;
        end else begin
            bar_wait_ff <= BAR_REQ | (bar_wait_ff & ~bar_fin);
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            bar_done_ff <= 1'b0;
        end else begin
            bar_done_ff <= bar_fin;
        end
    end

    // ==========================================================
    // error classification and routing
    logic steered;
    logic [IDW-1:0] target;
    logic deliver;
    logic [NUM_STRANDS-1:0] deliver_vec;

    // the handler is read once here and feeds record and trap alike
    assign steered = ERR_IN.valid & ERR_IN.shared
                     & ~ERR_IN.traceable;
    assign target = steered ? handler_ff
                    : ERR_IN.strand;
    // a disabled or missing target takes nothing; others untouched
    assign deliver = ERR_IN.valid & avail_w[target]
                     & enab_w[target];
    assign deliver_vec = deliver ? onehot_n(target) : '0;

    logic [NUM_STRANDS-1:0] report_valid_ff;
    ses_pkg::ses_rpt_type report_info_ff;

    // record goes out in the cycle the exception becomes pending
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            report_valid_ff <= '0;
        end else begin
            report_valid_ff <= deliver_vec;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            report_info_ff <= '0;
        end else if (deliver) begin
            report_info_ff.sync <= ERR_IN.sync & ~steered;
            report_info_ff.steered <= steered;
            report_info_ff.code <= ERR_IN.code;
        end
    end

    // ==========================================================
    // exception holding per strand
    logic [NUM_STRANDS-1:0] trap_pend;
    logic [NUM_STRANDS-1:0] trap_req_w;

    ses_trap_hold #(
        .N(NUM_STRANDS)
    ) u_hold (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .set(deliver_vec),
        .parked(STRAND_PARKED),
        .pend(trap_pend),
        .trap(trap_req_w)
    );

    // ==========================================================
    // outputs
    assign ASI_ACK = ack_ff;
    assign ASI_RDATA = rdata_ff;
    assign BAR_DONE = bar_done_ff;
    assign REPORT_VALID = report_valid_ff;
    assign REPORT_INFO = report_info_ff;
    assign TRAP_REQ = trap_req_w;
    assign HANDLER = handler_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    property p_private;
        ERR_IN.valid && !ERR_IN.shared && deliver
        |=> report_valid_ff == onehot_n($past(ERR_IN.strand));
    endproperty
    a_private: assert property (p_private)
        else $error("private error not sent to its own strand");

    property p_traced;
        ERR_IN.valid && ERR_IN.shared && ERR_IN.traceable && deliver
        |=> report_valid_ff == onehot_n($past(ERR_IN.strand))
            && report_info_ff.steered == 1'b0;
    endproperty
    a_traced: assert property (p_traced)
        else $error("traceable shared error not returned to origin");

    property p_steer;
        steered && deliver
        |=> report_valid_ff == onehot_n($past(handler_ff))
            && report_info_ff.steered;
    endproperty
    a_steer: assert property (p_steer)
        else $error("steered error not sent to handler strand");

    property p_record_trap;
        report_valid_ff != '0
        |-> (trap_pend & report_valid_ff) == report_valid_ff;
    endproperty
    a_record_trap: assert property (p_record_trap)
        else $error("record delivered without pending exception");

    property p_single;
        $onehot0(report_valid_ff);
    endproperty
    a_single: assert property (p_single)
        else $error("error recorded on more than one strand");

    property p_unavail;
        ERR_IN.valid && !deliver |=> report_valid_ff == '0;
    endproperty
    a_unavail: assert property (p_unavail)
        else $error("error delivered to unavailable strand");

    property p_upper_zero;
        (handler_ff & ~ID_MASK) == '0
        && (ASI_RDATA >> IMPL_W) == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("unimplemented handler bits not zero");

    property p_write;
        wr_now ##1 (!WARM_RESET && !por_init_ff)
        |=> handler_ff == ($past(ASI_REQ.wdata[IDW-1:0], 2) & ID_MASK);
    endproperty
    a_write: assert property (p_write)
        else $error("store did not update handler in two cycles");

    property p_barrier;
        BAR_REQ ##1 !wr_now |-> ##[1:2] bar_done_ff;
    endproperty
    a_barrier: assert property (p_barrier)
        else $error("barrier did not complete after store");

    property p_warm;
        WARM_RESET && !por_init_ff
        |=> handler_ff == ses_pkg::ses_lowest($past(enab_w));
    endproperty
    a_warm: assert property (p_warm)
        else $error("warm reset did not select lowest enabled strand");

    // on the release edge reset still reads low in the sampled values,
    // and the handler load only lands one edge later
    property p_por;
        RESET_N && por_init_ff
        |=> handler_ff == ses_pkg::ses_lowest($past(avail_w));
    endproperty
    a_por: assert property (p_por)
        else $error("power-on did not select lowest available strand");

    c_steered: cover property (steered && deliver ##1 report_valid_ff != '0);
    c_dropped: cover property (ERR_IN.valid && !deliver);
    c_warm: cover property (WARM_RESET && !por_init_ff);
    c_parked: cover property (
        (trap_pend & STRAND_PARKED) != '0 ##[1:20] TRAP_REQ != '0);
    c_barrier: cover property (wr_now ##1 BAR_REQ ##[1:3] bar_done_ff);

endmodule // ses_error_steer

//--- ses_strand_model.sv
/*
 * strand-side model: counts error records and traps per delivery.
 * assumes the block's strand outputs are one-cycle pulses on clk.
 */
`timescale 1ns/1ps
module ses_strand_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // strand side of the block
    input wire logic [63:0] report_valid,
    input wire logic [63:0] trap_req,
    // bookkeeping for the bench
    output logic [7:0] rpt_cnt,
    output logic [7:0] trap_cnt,
    output logic [5:0] last_rpt,
    output logic [5:0] last_trap,
    output logic multi_hit
);
    // ==========================================================
    // records: a real strand takes one record per pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rpt_cnt <= 8'h00;
            trap_cnt <= 8'h00;
            last_rpt <= 6'h00;
            last_trap <= 6'h00;
            multi_hit <= 1'b0;
        end else begin
            if (|report_valid) begin
                rpt_cnt <= rpt_cnt + 8'h01;
            end
            if (|trap_req) begin
                trap_cnt <= trap_cnt + 8'h01;
            end
            if ($countones(report_valid) > 1 || $countones(trap_req) > 1) begin
                multi_hit <= 1'b1;
            end
            for (int i = 0; i < 64; i++) begin
                if (report_valid[i]) begin
                    last_rpt <= 6'(i);
                end
                if (trap_req[i]) begin
                    last_trap <= 6'(i);
                end
            end
        end
    end
endmodule // ses_strand_model

//--- ses_error_steer_tb_top.sv
/*
 * testbench for the error steering block: register access, barrier,
 * steering, parking, dropping and reset loads.
 * assumes 64 strands and the alternate-space location of the package.
 */
`timescale 1ns/1ps
module ses_error_steer_tb_top;
    // ==========================================================
    // signals
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic warm_reset = 1'b0;
    ses_pkg::ses_err_type err_in = '0;
    logic [63:0] avail = 64'hffff_ffff_ffff_fffc;
    logic [63:0] enable = 64'hffff_ffff_ffff_fff8;
    logic [63:0] parked = 64'h0;
    ses_pkg::ses_asi_req_type asi_req = '0;
    logic bar_req = 1'b0;
    logic asi_ack;
    logic [63:0] asi_rdata;
    logic bar_done;
    logic [63:0] report_valid;
    ses_pkg::ses_rpt_type report_info;
    logic [63:0] trap_req;
    logic [5:0] handler;
    logic [7:0] rpt_cnt;
    logic [7:0] trap_cnt;
    logic [5:0] last_rpt;
    logic [5:0] last_trap;
    logic multi_hit;
    logic [63:0] rd;
    logic [7:0] r0;
    logic [7:0] t0;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [15:0] VA = ses_pkg::SES_STEER_VA;

    initial begin
        forever #12.5 clock = ~clock;
    end

    ses_error_steer dut (
        .CLOCK(clock), .RESET_N(reset_n), .WARM_RESET(warm_reset),
        .ERR_IN(err_in), .STRAND_AVAILABLE(avail),
        .STRAND_ENABLE(enable), .STRAND_PARKED(parked),
        .ASI_REQ(asi_req), .ASI_ACK(asi_ack), .ASI_RDATA(asi_rdata),
        .BAR_REQ(bar_req), .BAR_DONE(bar_done),
        .REPORT_VALID(report_valid), .REPORT_INFO(report_info),
        .TRAP_REQ(trap_req), .HANDLER(handler)
    );

    ses_strand_model strands (
        .clk(clock), .rst_n(reset_n), .report_valid(report_valid),
        .trap_req(trap_req), .rpt_cnt(rpt_cnt), .trap_cnt(trap_cnt),
        .last_rpt(last_rpt), .last_trap(last_trap), .multi_hit(multi_hit)
    );

    // ==========================================================
    // tasks
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one request cycle; ack lands right after the taking edge
    task automatic asi_op(input logic wr, input logic [15:0] va,
        input logic [63:0] wd, input logic bar, output logic [63:0] q);
        @(posedge clock);
        asi_req <= '{1'b1, wr, ses_pkg::SES_STEER_ASI, va, wd};
        bar_req <= bar;
        @(posedge clock);
        asi_req <= '0;
        bar_req <= 1'b0;
        #1;
        check(64'(asi_ack), 64'h1);
        q = asi_rdata;
    endtask

    task automatic fire(input logic sh, input logic tr, input logic sy,
        input logic [5:0] st);
        @(posedge clock);
        err_in <= '{1'b1, sh, tr, sy, st, {2'h0, st}};
        @(posedge clock);
        err_in <= '0;
    endtask

    task automatic err_case(input logic sh, input logic tr, input logic sy,
        input logic [5:0] st, input logic [5:0] ex, input logic steer);
        fire(sh, tr, sy, st);
        #1;
        check(report_valid, 64'h1 << ex);
        check(64'(report_info), 64'({sy & ~steer, steer, 2'h0, st}));
        @(posedge clock);
        #1;
        check(trap_req, 64'h1 << ex);
        check(report_valid, 64'h0);
    endtask

    // ==========================================================
    // timeout: the whole sequence needs about 65 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            test_done();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(64'(handler), 64'h2);
        asi_op(1'b0, VA, 64'h0, 1'b0, rd);
        check(rd, 64'h2);
        asi_op(1'b1, VA + 16'h0008, 64'h9, 1'b0, rd);
        check(rd, 64'h0);
        asi_op(1'b0, VA, 64'h0, 1'b0, rd);
        check(rd, 64'h2);
        asi_op(1'b1, VA, 64'hffff_ffff_ffff_ffc5, 1'b0, rd);
        asi_op(1'b0, VA, 64'h0, 1'b0, rd);
        check(rd, 64'h5);
        $display("test register access done");
        asi_op(1'b1, VA, 64'h6, 1'b1, rd);
        for (int i = 0; i < 4 && bar_done !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        check(64'(bar_done), 64'h1);
        check(64'(handler), 64'h6);
        $display("test barrier done");
        err_case(1'b0, 1'b0, 1'b1, 6'd9, 6'd9, 1'b0);
        err_case(1'b1, 1'b1, 1'b0, 6'd10, 6'd10, 1'b0);
        err_case(1'b1, 1'b0, 1'b1, 6'd11, 6'd6, 1'b1);
        $display("test routing done");
        @(posedge clock);
        parked <= 64'h1 << 6;
        fire(1'b1, 1'b0, 1'b0, 6'd12);
        #1;
        // count taken only after the last routing trap has been counted
        t0 = trap_cnt;
        check(report_valid, 64'h1 << 6);
        repeat (4) @(posedge clock);
        #1;
        check(64'(trap_cnt), 64'(t0));
        @(posedge clock);
        parked <= 64'h0;
        repeat (3) @(posedge clock);
        #1;
        check(64'(trap_cnt), 64'(t0 + 8'h01));
        check(64'(last_trap), 64'h6);
        $display("test parked done");
        // strand 1 is outside the available set on purpose
        asi_op(1'b1, VA, 64'h1, 1'b0, rd);
        r0 = rpt_cnt;
        t0 = trap_cnt;
        fire(1'b1, 1'b0, 1'b0, 6'd13);
        repeat (4) @(posedge clock);
        #1;
        check(64'(rpt_cnt), 64'(r0));
        check(64'(trap_cnt), 64'(t0));
        // strand 2 is available but not enabled: dropped as well
        asi_op(1'b1, VA, 64'h2, 1'b0, rd);
        fire(1'b1, 1'b0, 1'b0, 6'd15);
        repeat (4) @(posedge clock);
        #1;
        check(64'(rpt_cnt), 64'(r0));
        check(64'(trap_cnt), 64'(t0));
        $display("test dropped done");
        asi_op(1'b1, VA, 64'h4, 1'b0, rd);
        r0 = rpt_cnt;
        t0 = trap_cnt;
        fork
            asi_op(1'b1, VA, 64'h7, 1'b0, rd);
            fire(1'b1, 1'b0, 1'b0, 6'd14);
        join
        repeat (3) @(posedge clock);
        #1;
        check(64'(last_rpt), 64'(last_trap));
        check(64'(last_rpt == 6'h4 || last_rpt == 6'h7), 64'h1);
        check(64'(rpt_cnt), 64'(r0 + 8'h01));
        check(64'(trap_cnt), 64'(t0 + 8'h01));
        $display("test race done");
        @(posedge clock);
        warm_reset <= 1'b1;
        @(posedge clock);
        warm_reset <= 1'b0;
        #1;
        check(64'(handler), 64'h3);
        check(64'(multi_hit), 64'h0);
        $display("test warm reset done");
        test_done();
    end
endmodule // ses_error_steer_tb_top
